/* File: core/link_ctrl_pkg.sv */
package link_ctrl_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_RESET_MASK = 8'h46;
	localparam logic [7:0] IDX_ALIGN = 8'h49;
	localparam logic [7:0] IDX_TEST_SYNC = 8'h4A;
	localparam logic [7:0] IDX_FORCED_K = 8'h53;
	localparam logic [7:0] IDX_STATUS = 8'h60;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam logic [15:0] REG_RESET = 16'h0000;
	// Field positions
	localparam int B_TRIG_MASK = 2;
	localparam int B_NONLINK_MASK = 1;
	localparam int B_IDLE = 15;
	localparam int B_LANE_ALIGN = 12;
	localparam int B_FRAME_ALIGN = 11;
	localparam int B_ILA_SKIP = 10;
	localparam int B_FORCE_K = 2;
	localparam int B_TEST_HI = 15;
	localparam int B_TEST_LO = 13;
	localparam int B_RESYNC = 12;
	localparam int B_RELEASE_HI = 11;
	localparam int B_RELEASE_LO = 10;
	localparam int B_PARTIAL = 8;
	localparam int B_FIRST_EVENT = 7;
	localparam int B_FORCED_K_HI = 4;
	localparam int B_STATUS_STATE_LO = 8;
	localparam int B_STATUS_SYNC = 15;
	// Octet codes before 8b/10b encoding
	localparam logic [7:0] K28_0 = 8'h1C;
	localparam logic [7:0] K28_3 = 8'h7C;
	localparam logic [7:0] K28_4 = 8'h9C;
	localparam logic [7:0] K28_5 = 8'hBC;
	localparam logic [7:0] K28_7 = 8'hFC;
	localparam logic [7:0] D21_5 = 8'hB5;
	localparam logic [15:0] IDLE_WORD = 16'hBC50;
	localparam logic [2:0] TM_NORMAL = 3'h0;
	localparam logic [2:0] TM_D21_5 = 3'h1;
	localparam logic [2:0] TM_K28_5 = 3'h2;
	localparam logic [2:0] TM_ILA = 3'h3;
	localparam logic [2:0] TM_PRBS = 3'h4;
	localparam logic [6:0] PRBS_SEED = 7'h7F;
	localparam logic [3:0] PRBS_OCTETS = 4'hF;
	localparam logic [1:0] ILA_LAST_MF = 2'h3;
	localparam int MF_OCTETS_MIN = 17;
	localparam int K_MAX = 32;
	typedef enum logic [1:0] {ST_CGS, ST_WAIT_LMFC, ST_ILA, ST_DATA} link_state_e;
	typedef struct packed {
		logic ctrl;
		logic [7:0] value;
	} tx_octet_s;
	typedef struct packed {
		logic link;
		logic divider;
		logic demod;
		logic pattern_gen;
	} phase_reset_s;
endpackage

/* File: core/serial_link_layer_control.sv */
`timescale 1ns/1ns
module serial_link_layer_control import link_ctrl_pkg::*; #(
	parameter int FRAME_OCTETS = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sync_n,
	input wire logic sysref,
	input wire logic external_transmit_trigger,
	input wire logic [7:0] in_octet,
	input wire logic in_valid,
	output logic in_ready,
	output tx_octet_s tx_octet,
	output logic tx_valid,
	input wire logic tx_ready,
	output phase_reset_s phase_reset
);
	localparam int AUTO_K = (MF_OCTETS_MIN + FRAME_OCTETS - 1) / FRAME_OCTETS;
	localparam logic [4:0] AUTO_K_MINUS1 = 5'(AUTO_K - 1);
	localparam int OCT_W = (FRAME_OCTETS > 1) ? $clog2(FRAME_OCTETS) : 1;
	localparam logic [OCT_W-1:0] OCT_LAST = OCT_W'(FRAME_OCTETS - 1);

	generate
		if (FRAME_OCTETS < 1 || FRAME_OCTETS > 16 || AUTO_K > K_MAX) begin : g_bad
			$error("FRAME_OCTETS out of range");
		end
	endgenerate

	function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[9:2];
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] i;
		i = reg_index(a);
		mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0) &&
			(i == IDX_RESET_MASK || i == IDX_ALIGN || i == IDX_TEST_SYNC ||
			i == IDX_FORCED_K || i == IDX_STATUS);
	endfunction

	// Control fields
	logic trigger_phase_reset_mask, nonlink_reset_mask;
	logic idle_en, lane_align_en, frame_align_en, initial_alignment_skip;
	logic force_k, resync_req, partial_phase_reset_option;
	logic first_event_full_reset_option;
	logic [2:0] link_test_pattern_select;
	logic [1:0] alignment_release_edge_select;
	logic [4:0] forced_multiframe_length;
	logic [4:0] k_minus1;
	link_state_e state;
	logic sync_m, sync_s, sync_d, sref_m, sref_s, sref_d;
	logic trig_m, trig_s, trig_d;

	// APB slave: pready rises in the access phase, one wait-free answer
	logic wr_en;
	assign wr_en = psel && penable && pready && pwrite && !pslverr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped(paddr);
			if (psel && !penable) begin
				prdata <= '0;
				// Refused addresses read zero even if the index matches
				case (mapped(paddr) ? reg_index(paddr) : 8'h00)
					IDX_RESET_MASK: begin
						prdata[B_TRIG_MASK] <= trigger_phase_reset_mask;
						prdata[B_NONLINK_MASK] <= nonlink_reset_mask;
					end
					IDX_ALIGN: begin
						prdata[B_IDLE] <= idle_en;
						prdata[B_LANE_ALIGN] <= lane_align_en;
						prdata[B_FRAME_ALIGN] <= frame_align_en;
						prdata[B_ILA_SKIP] <= initial_alignment_skip;
						prdata[B_FORCE_K] <= force_k;
					end
					IDX_TEST_SYNC: begin
						prdata[B_TEST_HI:B_TEST_LO] <= link_test_pattern_select;
						prdata[B_RESYNC] <= resync_req;
						prdata[B_RELEASE_HI:B_RELEASE_LO] <=
							alignment_release_edge_select;
						prdata[B_PARTIAL] <= partial_phase_reset_option;
						prdata[B_FIRST_EVENT] <= first_event_full_reset_option;
					end
					IDX_FORCED_K: begin
						prdata[B_FORCED_K_HI:0] <= forced_multiframe_length;
					end
					IDX_STATUS: begin
						prdata[B_FORCED_K_HI:0] <= k_minus1;
						prdata[B_STATUS_STATE_LO+1:B_STATUS_STATE_LO] <= state;
						prdata[B_STATUS_SYNC] <= sync_s;
					end
					default: prdata <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{trigger_phase_reset_mask, nonlink_reset_mask} <= 2'h0;
			{idle_en, lane_align_en, frame_align_en} <= 3'h0;
			{initial_alignment_skip, force_k, resync_req} <= 3'h0;
			partial_phase_reset_option <= 1'b0;
			first_event_full_reset_option <= 1'b0;
			link_test_pattern_select <= TM_NORMAL;
			alignment_release_edge_select <= 2'h0;
			forced_multiframe_length <= REG_RESET[B_FORCED_K_HI:0];
		end else if (wr_en) begin
			case (reg_index(paddr))
				IDX_RESET_MASK: begin
					trigger_phase_reset_mask <= pwdata[B_TRIG_MASK];
					nonlink_reset_mask <= pwdata[B_NONLINK_MASK];
				end
				IDX_ALIGN: begin
					idle_en <= pwdata[B_IDLE];
					lane_align_en <= pwdata[B_LANE_ALIGN];
					frame_align_en <= pwdata[B_FRAME_ALIGN];
					initial_alignment_skip <= pwdata[B_ILA_SKIP];
					force_k <= pwdata[B_FORCE_K];
				end
				IDX_TEST_SYNC: begin
					link_test_pattern_select <= pwdata[B_TEST_HI:B_TEST_LO];
					resync_req <= pwdata[B_RESYNC];
					alignment_release_edge_select <=
						pwdata[B_RELEASE_HI:B_RELEASE_LO];
					partial_phase_reset_option <= pwdata[B_PARTIAL];
					first_event_full_reset_option <= pwdata[B_FIRST_EVENT];
				end
				IDX_FORCED_K: forced_multiframe_length <= pwdata[B_FORCED_K_HI:0];
				default: ;
			endcase
		end
	end

	assign k_minus1 = force_k ? forced_multiframe_length : AUTO_K_MINUS1;

	// Pin synchronisers; the second stage gives the level, the second and third stages give the edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{sync_m, sync_s, sync_d} <= 3'b111;
			{sref_m, sref_s, sref_d} <= 3'b000;
			{trig_m, trig_s, trig_d} <= 3'b000;
		end else begin
			{sync_m, sync_s, sync_d} <= {sync_n, sync_m, sync_s};
			{sref_m, sref_s, sref_d} <= {sysref, sref_m, sref_s};
			{trig_m, trig_s, trig_d} <= {external_transmit_trigger, trig_m, trig_s};
		end
	end

	logic link_ev, trig_ev, first_armed, full_ev;
	assign link_ev = (sync_d && !sync_s) || (sref_s && !sref_d);
	assign trig_ev = trig_s && !trig_d;
	// Full reset unless a partial option applies
	assign full_ev = !partial_phase_reset_option &&
		(!first_event_full_reset_option || first_armed);

	// Arming on a write that sets the option wins over the event clearing it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_armed <= 1'b0;
		end else if (wr_en && reg_index(paddr) == IDX_TEST_SYNC &&
				pwdata[B_FIRST_EVENT] && !first_event_full_reset_option) begin
			first_armed <= 1'b1;
		end else if (link_ev) begin
			first_armed <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reset <= '0;
		end else begin
			phase_reset.link <= (trig_ev && !trigger_phase_reset_mask) ||
				(link_ev && full_ev);
			phase_reset.divider <= (trig_ev && !trigger_phase_reset_mask) ||
				(link_ev && full_ev && !nonlink_reset_mask);
			phase_reset.demod <= (trig_ev && !trigger_phase_reset_mask) ||
				(link_ev && !nonlink_reset_mask);
			phase_reset.pattern_gen <= (trig_ev && !trigger_phase_reset_mask) ||
				(link_ev && !nonlink_reset_mask);
		end
	end

	// Two-entry skid buffer keeps every octet when the serializer stalls
	tx_octet_s next_octet, skid;
	logic skid_valid, push, buf_ready;
	assign buf_ready = !skid_valid;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_valid <= 1'b0;
			tx_octet <= '0;
			skid <= '0;
			skid_valid <= 1'b0;
		end else if (tx_ready || !tx_valid) begin
			if (skid_valid) begin
				tx_octet <= skid;
				skid_valid <= 1'b0;
			end else if (push) begin
				tx_octet <= next_octet;
			end
			tx_valid <= skid_valid || push;
		end else if (push) begin
			skid <= next_octet;
			skid_valid <= 1'b1;
		end
	end

	// Frame and multiframe position
	logic [OCT_W-1:0] oct_cnt;
	logic [4:0] frm_cnt;
	logic end_frame, end_mf, data_phase;
	assign end_frame = oct_cnt == OCT_LAST;
	// A shorter K takes effect at once instead of after a counter wrap
	assign end_mf = end_frame && frm_cnt >= k_minus1;
	assign data_phase = state == ST_DATA && !idle_en && !resync_req &&
		link_test_pattern_select == TM_NORMAL;
	// Output port in_ready is decoded from flops only, with no path from inputs
	assign in_ready = buf_ready && data_phase;
	assign push = buf_ready && (!data_phase || in_valid);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oct_cnt <= '0;
			frm_cnt <= '0;
		end else if (phase_reset.link) begin
			oct_cnt <= '0;
			frm_cnt <= '0;
		end else if (push) begin
			oct_cnt <= end_frame ? '0 : oct_cnt + 1'b1;
			if (end_frame) begin
				frm_cnt <= end_mf ? 5'h0 : frm_cnt + 5'h1;
			end
		end
	end

	// Link start-up sequence
	logic [1:0] ila_mf, release_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_CGS;
			ila_mf <= 2'h0;
			release_cnt <= 2'h0;
		end else begin
			if (push && end_mf) begin
				ila_mf <= ila_mf + 2'h1;
			end
			case (state)
				ST_CGS: begin
					release_cnt <= 2'h0;
					if (sync_s && !resync_req) begin
						state <= initial_alignment_skip ? ST_DATA : ST_WAIT_LMFC;
					end
				end
				ST_WAIT_LMFC: begin
					if (push && end_mf) begin
						release_cnt <= release_cnt + 2'h1;
						if (release_cnt == alignment_release_edge_select) begin
							state <= ST_ILA;
							ila_mf <= 2'h0;
						end
					end
				end
				ST_ILA: begin
					if (push && end_mf && ila_mf == ILA_LAST_MF) begin
						state <= ST_DATA;
					end
				end
				ST_DATA: ;
				default: state <= ST_CGS;
			endcase
			// Resync or receiver request restarts start-up
			if (!sync_s || resync_req) begin
				state <= ST_CGS;
			end
		end
	end

	// Pseudo-random 120-bit pattern
	logic [6:0] lfsr;
	logic [3:0] prbs_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr <= PRBS_SEED;
			prbs_cnt <= '0;
		end else if (push && link_test_pattern_select == TM_PRBS) begin
			prbs_cnt <= (prbs_cnt == PRBS_OCTETS - 4'h1) ? 4'h0 : prbs_cnt + 4'h1;
			lfsr <= (prbs_cnt == PRBS_OCTETS - 4'h1) ? PRBS_SEED :
				{lfsr[5:0], lfsr[6] ^ lfsr[5]};
		end
	end

	// Alignment history, kept on unencoded octets
	logic [7:0] prev_frame_last, prev_mf_last;
	logic ctrl_this_frame, ctrl_prev_frame;
	logic mf_hit, fr_hit;
	assign mf_hit = lane_align_en && end_mf && in_octet == prev_mf_last;
	assign fr_hit = frame_align_en && end_frame && !ctrl_prev_frame &&
		in_octet == prev_frame_last;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_frame_last <= '0;
			prev_mf_last <= '0;
			ctrl_this_frame <= 1'b0;
			ctrl_prev_frame <= 1'b0;
		end else if (push) begin
			if (end_frame) begin
				ctrl_prev_frame <= ctrl_this_frame || next_octet.ctrl;
				ctrl_this_frame <= 1'b0;
				if (data_phase) begin
					prev_frame_last <= in_octet;
				end
				if (data_phase && end_mf) begin
					prev_mf_last <= in_octet;
				end
			end else begin
				ctrl_this_frame <= ctrl_this_frame || next_octet.ctrl;
			end
		end
	end

	tx_octet_s ila_octet;
	always_comb begin
		ila_octet = '{ctrl: 1'b0, value: {3'h0, frm_cnt}};
		if (oct_cnt == '0 && frm_cnt == 5'h0) begin
			ila_octet = '{ctrl: 1'b1, value: K28_0};
		end else if (ila_mf == 2'h1 && oct_cnt == 1 && frm_cnt == 5'h0) begin
			ila_octet = '{ctrl: 1'b1, value: K28_4};
		end else if (end_mf) begin
			ila_octet = '{ctrl: 1'b1, value: K28_3};
		end
	end

	always_comb begin
		next_octet = '{ctrl: 1'b1, value: K28_5};
		if (idle_en) begin
			next_octet = '{ctrl: 1'b0,
				value: oct_cnt[0] ? IDLE_WORD[7:0] : IDLE_WORD[15:8]};
		end else if (link_test_pattern_select != TM_NORMAL) begin
			case (link_test_pattern_select)
				TM_D21_5: next_octet = '{ctrl: 1'b0, value: D21_5};
				TM_K28_5: next_octet = '{ctrl: 1'b1, value: K28_5};
				TM_ILA: next_octet = ila_octet;
				TM_PRBS: next_octet = '{ctrl: 1'b0, value: {lfsr, lfsr[0]}};
				default: next_octet = '{ctrl: 1'b0, value: 8'h00};
			endcase
		end else if (state == ST_ILA && !resync_req) begin
			next_octet = ila_octet;
		end else if (data_phase) begin
			next_octet = '{ctrl: 1'b0, value: in_octet};
			if (mf_hit) begin
				next_octet = '{ctrl: 1'b1, value: K28_3};
			end else if (fr_hit) begin
				next_octet = '{ctrl: 1'b1, value: K28_7};
			end
		end
	end

	AST_TRIG_MASK: assert property (
		@(posedge pclk) disable iff (!presetn)
		trig_ev && trigger_phase_reset_mask && !link_ev |=> phase_reset == '0)
		else $error("masked trigger caused a phase reset");
	AST_NONLINK: assert property (
		@(posedge pclk) disable iff (!presetn)
		link_ev && !trig_ev && nonlink_reset_mask |=>
		!phase_reset.divider && !phase_reset.demod && !phase_reset.pattern_gen)
		else $error("masked event reset non-link blocks");
	AST_PARTIAL: assert property (
		@(posedge pclk) disable iff (!presetn)
		link_ev && !trig_ev && partial_phase_reset_option && !nonlink_reset_mask
		|=> !phase_reset.link && !phase_reset.divider && phase_reset.demod)
		else $error("partial option reset wrong blocks");
	AST_IDLE: assert property (
		@(posedge pclk) disable iff (!presetn)
		idle_en && push |-> !next_octet.ctrl &&
		(next_octet.value == IDLE_WORD[15:8] ||
		next_octet.value == IDLE_WORD[7:0]))
		else $error("idle pattern not sent");
	AST_MF_ALIGN: assert property (
		@(posedge pclk) disable iff (!presetn)
		data_phase && push && mf_hit |-> next_octet == tx_octet_s'{1'b1, K28_3})
		else $error("missing K28.3 substitution");
	AST_FR_SKIP: assert property (
		@(posedge pclk) disable iff (!presetn)
		data_phase && push && end_frame && !end_mf && ctrl_prev_frame
		|-> next_octet.value == in_octet)
		else $error("frame substitution after control character");
	AST_SKIP_ILA: assert property (
		@(posedge pclk) disable iff (!presetn)
		state == ST_CGS && sync_s && !resync_req && initial_alignment_skip
		|=> state == ST_DATA || !sync_s)
		else $error("alignment sequence not skipped");
	AST_ILA_ON: assert property (
		@(posedge pclk) disable iff (!presetn)
		state == ST_CGS && sync_s && !resync_req && !initial_alignment_skip
		|=> state != ST_DATA)
		else $error("payload without alignment sequence");
	AST_RESYNC: assert property (
		@(posedge pclk) disable iff (!presetn)
		resync_req && !idle_en && link_test_pattern_select == TM_NORMAL && push
		|-> next_octet == tx_octet_s'{1'b1, K28_5})
		else $error("resync request did not send K28.5");
	COV_ILA: cover property (@(posedge pclk) disable iff (!presetn)
		state == ST_ILA ##1 state == ST_DATA);
	COV_MF: cover property (@(posedge pclk) disable iff (!presetn)
		data_phase && push && mf_hit);
	COV_STALL: cover property (@(posedge pclk) disable iff (!presetn)
		skid_valid && !tx_ready);
endmodule // serial_link_layer_control

/* File: tb/link_rx_model.sv */
`timescale 1ns/1ns
module link_rx_model import link_ctrl_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic stall_en,
	input wire logic sync_req,
	input wire tx_octet_s tx_octet,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic sync_n,
	output logic got,
	output tx_octet_s got_octet
);
	int seed = 9305;
	// Random stalls keep the two-entry buffer busy
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ready <= 1'b0;
			sync_n <= 1'b1;
		end else begin
			tx_ready <= stall_en ? 1'($random(seed)) : 1'b1;
			sync_n <= !sync_req;
		end
	end
	assign got = tx_valid && tx_ready;
	assign got_octet = tx_octet;
endmodule // link_rx_model

/* File: tb/serial_link_layer_control_test.sv */
`timescale 1ns/1ns
module serial_link_layer_control_test;
	import link_ctrl_pkg::*;
	localparam int F = 2;
	localparam int KA = (MF_OCTETS_MIN + F - 1) / F;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata;
	logic pready, pslverr, sync_n, sysref = 0, trig = 0;
	logic [7:0] in_octet = '0;
	logic in_valid = 0, in_ready, tx_valid, tx_ready, got;
	logic stall_en = 1, sync_req = 1, collect = 0, pr_clr = 0;
	tx_octet_s tx_octet, got_octet;
	phase_reset_s phase_reset;
	logic [3:0] pr_seen = '0;
	tx_octet_s log_q[$];
	logic [7:0] exp_q[$];
	int n_errors = 0, check_count = 0, cyc = 0, seed = 9305;
	logic [31:0] r, v;
	logic e;
	logic [7:0] ridx[3] = '{IDX_RESET_MASK, IDX_ALIGN, IDX_TEST_SYNC};
	logic [15:0] rmsk[3] = '{16'h0006, 16'h9C04, 16'hFD80};
	logic [15:0] acfg[4] = '{16'h0400, 16'h0C00, 16'h1400, 16'h1404};
	logic [7:0] ak[4] = '{K28_7, K28_7, K28_3, K28_3};
	int agap[4] = '{F * 2, F * 2, KA * F, 4 * F};
	int amin[4] = '{0, 9, 2, 5};
	logic [15:0] tm[5] = '{16'h2000, 16'h4000, 16'h6000, 16'h8000, 16'h1000};
	logic [7:0] pidx[7] = '{IDX_RESET_MASK, IDX_RESET_MASK, IDX_RESET_MASK,
		IDX_RESET_MASK, IDX_TEST_SYNC, IDX_TEST_SYNC, IDX_TEST_SYNC};
	logic [15:0] pval[7] = '{16'h0000, 16'h0004, 16'h0002, 16'h0000,
		16'h0100, 16'h0080, 16'h0080};
	bit ptrg[7] = '{1, 1, 0, 0, 0, 0, 0};
	logic [3:0] pexp[7] = '{4'hF, 4'h0, 4'h8, 4'hF, 4'h3, 4'hF, 4'h3};

	always #20 pclk = ~pclk;

	serial_link_layer_control #(.FRAME_OCTETS(F)) u_serial_link_layer_control (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sync_n(sync_n), .sysref(sysref),
		.external_transmit_trigger(trig), .in_octet(in_octet),
		.in_valid(in_valid), .in_ready(in_ready), .tx_octet(tx_octet),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .phase_reset(phase_reset));

	link_rx_model u_link_rx_model (.pclk(pclk), .presetn(presetn),
		.stall_en(stall_en), .sync_req(sync_req), .tx_octet(tx_octet),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .sync_n(sync_n),
		.got(got), .got_octet(got_octet));

	task automatic check(input logic [31:0] gv, input logic [31:0] ev);
		check_count++;
		if (gv !== ev) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, gv, ev);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	function automatic logic [11:0] ba(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, ba(idx), {16'h0000, d}, rd, er);
	endtask

	task automatic wait_state(input link_state_e st);
		logic [31:0] rd;
		logic er;
		do apb(1'b0, ba(IDX_STATUS), '0, rd, er);
		while (rd[9:8] !== st);
	endtask

	// Sender notes each accepted random payload octet for the monitor
	task automatic send(input int n, input bit rnd);
		logic [7:0] d;
		// Leftover start-up octets would reach the monitor before payload
		while (tx_valid === 1'b1) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			d = rnd ? 8'($random(seed)) : 8'h22;
			in_valid <= 1'b1;
			in_octet <= d;
			do @(posedge pclk); while (in_ready !== 1'b1);
			if (rnd)
				exp_q.push_back(d);
		end
		in_valid <= 1'b0;
	endtask

	// Old octets still sit in the buffer, so let them drain first
	task automatic grab(input int n);
		repeat (24) @(posedge pclk);
		log_q.delete();
		collect <= 1'b1;
		while (log_q.size() < n) @(posedge pclk);
		collect <= 1'b0;
	endtask

	// Count of k in the log, or -1 if two of them are not gap apart
	function automatic int gaps(input tx_octet_s k, input int gap);
		int last = -1, c = 0, bad = 0;
		foreach (log_q[i]) if (log_q[i] === k) begin
			if (last >= 0 && i - last != gap)
				bad = 1;
			last = i;
			c++;
		end
		return bad ? -1 : c;
	endfunction

	always @(posedge pclk) begin
		if (got === 1'b1) begin
			if (exp_q.size() > 0)
				check({23'h0, got_octet}, {24'h0, exp_q.pop_front()});
			else if (collect)
				log_q.push_back(got_octet);
		end
	end

	always @(posedge pclk) pr_seen <= pr_clr ? 4'h0 : pr_seen | phase_reset;

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			finish_test();
		end
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, ba(ridx[i]), '0, r, e);
			check(r, 32'h0);
			v = $random(seed);
			apb(1'b1, ba(ridx[i]), v, r, e);
			apb(1'b0, ba(ridx[i]), '0, r, e);
			check(r, v & {16'h0000, rmsk[i]});
			wr(ridx[i], 16'h0000);
		end
		apb(1'b0, 12'h004, '0, r, e);
		check({r[30:0], e}, 32'h1);
		apb(1'b0, 12'h119, '0, r, e);
		check({31'h0, e}, 32'h1);
		apb(1'b0, ba(IDX_STATUS), '0, r, e);
		check({27'h0, r[4:0]}, 32'(KA - 1));
		wr(IDX_FORCED_K, 16'h0003);
		wr(IDX_ALIGN, 16'h0004);
		apb(1'b0, ba(IDX_STATUS), '0, r, e);
		check({27'h0, r[4:0]}, 32'h3);
		$display("registers done");
		for (int s = 0; s < 2; s++) begin
			wr(IDX_ALIGN, s ? 16'h0400 : 16'h0000);
			sync_req <= 1'b1;
			repeat (20) @(posedge pclk);
			log_q.delete();
			collect <= 1'b1;
			sync_req <= 1'b0;
			wait_state(ST_DATA);
			collect <= 1'b0;
			check(32'(gaps({1'b1, K28_0}, KA * F)), s ? 0 : 4);
			check(32'(gaps({1'b1, K28_4}, 1)), s ? 0 : 1);
		end
		$display("start-up done");
		send(40, 1);
		repeat (30) @(posedge pclk);
		check(32'(exp_q.size()), 32'h0);
		$display("payload done");
		for (int c = 0; c < 4; c++) begin
			wr(IDX_ALIGN, acfg[c]);
			log_q.delete();
			collect <= 1'b1;
			send(54, 0);
			repeat (30) @(posedge pclk);
			collect <= 1'b0;
			v = 32'(gaps({1'b1, ak[c]}, agap[c]));
			check(32'(amin[c] == 0 ? v == 0 : $signed(v) >= amin[c]),
				1);
		end
		$display("alignment done");
		for (int m = 0; m < 5; m++) begin
			wr(IDX_TEST_SYNC, tm[m]);
			grab(30);
			if (m == 4)
				wait_state(ST_CGS);
			foreach (log_q[i]) case (m)
				0: check({23'h0, log_q[i]}, {24'h0, D21_5});
				1, 4: check({23'h0, log_q[i]}, {23'h1, K28_5});
				3: check({23'h0, log_q[i]}, {23'h0, log_q[i % 15]});
				default: ;
			endcase
			// Alignment run left K forced to four frames
			if (m == 2)
				check(32'(gaps({1'b1, K28_0}, 4 * F) > 0), 1);
		end
		wr(IDX_TEST_SYNC, 16'h0000);
		wr(IDX_ALIGN, 16'h8400);
		grab(20);
		for (int i = 0; i < 19; i++)
			check({log_q[i].ctrl, log_q[i].value ^ log_q[i + 1].value},
				{1'b0, IDLE_WORD[15:8] ^ IDLE_WORD[7:0]});
		wr(IDX_ALIGN, 16'h0400);
		$display("patterns done");
		for (int i = 0; i < 7; i++) begin
			wr(pidx[i], pval[i]);
			pr_clr <= 1'b1;
			@(posedge pclk);
			pr_clr <= 1'b0;
			if (ptrg[i])
				trig <= 1'b1;
			else
				sysref <= 1'b1;
			repeat (4) @(posedge pclk);
			trig <= 1'b0;
			sysref <= 1'b0;
			repeat (4) @(posedge pclk);
			check({28'h0, pr_seen}, {28'h0, pexp[i]});
		end
		$display("phase resets done");
		finish_test();
	end
endmodule // serial_link_layer_control_test
